// File: inc/adcs_pkg.sv
// shared constants and types for the converter sequencer
package adcs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_CONVERSION_RESULT = 8'h21;
  localparam logic [7:0] OFS_CONVERTER_CONTROL = 8'h22;
  localparam logic [7:0] OFS_CONVERTER_CLOCK_SELECT = 8'h23;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h24;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h25;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL_START_BIT = 7;
  localparam int CTL_FLAG_BIT = 6;
  localparam int CTL_PCR_LSB = 3;
  localparam int CTL_ACS_LSB = 0;
  localparam int CSR_TEST_BIT = 7;
  localparam int EVT_DONE_BIT = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONVERTER_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONVERTER_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] RST_CONVERSION_RESULT = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;
  localparam logic RST_PENDING_FLAG = 1'b0;

  // ----------------------------------------------------------------
  // converter clock dividers and their select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DIV_SEL_2 = 2'b00;
  localparam logic [1:0] DIV_SEL_8 = 2'b01;
  localparam logic [1:0] DIV_SEL_32 = 2'b10;
  localparam int DIV_2 = 2;
  localparam int DIV_8 = 8;
  localparam int DIV_32 = 32;
  localparam int DIV_CNT_W = 5;

  // ----------------------------------------------------------------
  // conversion
  // ----------------------------------------------------------------
  localparam int RESULT_W = 8;
  localparam int CHANNELS = 4;

  // one register access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } adcs_bus_req_s;

  // writable part of the converter control register
  typedef struct packed {
    logic start;
    logic [2:0] port_analog_config;
    logic [2:0] channel_select;
  } adcs_ctl_s;

  // conversion sequence states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HELD,
    ST_SAMPLE,
    ST_CONVERT
  } adcs_state_e;

endpackage

// File: verilog/adcs_clk_div.sv
// converter clock divider producing a one-cycle tick
`timescale 1ns/1ps
module adcs_clk_div
  import adcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] clock_divider_select,
  input wire logic clear,
  output logic tick
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DIV_CNT_W-1:0] cnt;
    logic tick;
  } adcs_div_s;

  adcs_div_s div_r;
  adcs_div_s div_nxt;
  logic [DIV_CNT_W-1:0] last;

  // terminal count per divider code; undefined code runs slowest
  always_comb
  begin
    case (clock_divider_select)
      DIV_SEL_2: last = DIV_CNT_W'(DIV_2 - 1);
      DIV_SEL_8: last = DIV_CNT_W'(DIV_8 - 1);
      DIV_SEL_32: last = DIV_CNT_W'(DIV_32 - 1);
      default: last = DIV_CNT_W'(DIV_32 - 1);
    endcase
  end

  // count, wrap and pulse; clear realigns phase at conversion start
  always_comb
  begin
    div_nxt = div_r;
    div_nxt.tick = 1'b0;
    if (clear)
    begin
      div_nxt.cnt = '0;
    end
    else if (div_r.cnt >= last)
    begin
      div_nxt.cnt = '0;
      div_nxt.tick = 1'b1;
    end
    else
    begin
      div_nxt.cnt = div_r.cnt + DIV_CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_r <= '0;
    end
    else
    begin
      div_r <= div_nxt;
    end
  end

  assign tick = div_r.tick;

endmodule // adcs_clk_div

// File: verilog/adcs_sequencer.sv
// successive-approximation converter sequencer with register port
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module adcs_sequencer
  import adcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire adcs_bus_req_s bus_req,
  output logic [DATA_W-1:0] rdata,
  input wire logic comparator_above,
  output logic [RESULT_W-1:0] trial_code,
  output logic [1:0] channel_select,
  output logic [CHANNELS-1:0] port_b_lines_analog,
  output logic converter_power,
  output logic sample_hold,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    adcs_state_e state;
    adcs_ctl_s ctl;
    logic pending;
    logic [1:0] clock_divider_select;
    logic test_bit;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] trial;
    logic [2:0] bit_idx;
    logic evt_status;
    logic evt_mask;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic [1:0] channel;
    logic [CHANNELS-1:0] analog_lines;
    logic power;
    logic sample;
  } adcs_seq_s;

  adcs_seq_s seq_r;
  adcs_seq_s seq_nxt;
  logic conv_tick;
  logic div_clear;
  adcs_ctl_s wr_ctl;
  logic wr_control;
  logic start_rise;
  logic start_fall;
  logic done;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // mask of the port lines handed to the converter
  function automatic logic [CHANNELS-1:0] analog_map(input logic [2:0] pcr);
    case (pcr)
      3'b000: analog_map = 4'h0;
      3'b001: analog_map = 4'h1;
      3'b010: analog_map = 4'h3;
      3'b011: analog_map = 4'h7;
      default: analog_map = 4'hf;
    endcase
  endfunction

  // one-hot weight of a trial bit
  function automatic logic [RESULT_W-1:0] bit_weight(input logic [2:0] idx);
    bit_weight = RESULT_W'(1) << idx;
  endfunction

  // ----------------------------------------------------------------
  // converter clock
  // ----------------------------------------------------------------
  // divider select drives the tick rate
  adcs_clk_div u_div (
    .core_clk(core_clk),
    .rst(rst),
    .clock_divider_select(seq_r.clock_divider_select),
    .clear(div_clear),
    .tick(conv_tick)
  );

  // write decode and start edges, seen against the stored start bit
  assign wr_control = bus_req.wr && (bus_req.addr == OFS_CONVERTER_CONTROL);
  assign wr_ctl = adcs_ctl_s'({bus_req.wdata[CTL_START_BIT],
                               bus_req.wdata[CTL_PCR_LSB +: 3],
                               bus_req.wdata[CTL_ACS_LSB +: 3]});
  assign start_rise = wr_control && wr_ctl.start && !seq_r.ctl.start;
  assign start_fall = wr_control && !wr_ctl.start && seq_r.ctl.start;
  // phase realigns when the held converter is released
  assign div_clear = start_fall;
  assign done = (seq_r.state == ST_CONVERT) && conv_tick && (seq_r.bit_idx == 3'd0);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    seq_nxt = seq_r;
    seq_nxt.sample = 1'b0;

    // register writes
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        OFS_CONVERTER_CONTROL:
        begin
          // config and channel stored as written
          seq_nxt.ctl = wr_ctl;
        end
        OFS_CONVERTER_CLOCK_SELECT:
        begin
          // low two bits choose the divider
          seq_nxt.clock_divider_select = bus_req.wdata[1:0];
          seq_nxt.test_bit = bus_req.wdata[CSR_TEST_BIT];
        end
        OFS_EVENT_MASK: seq_nxt.evt_mask = bus_req.wdata[EVT_DONE_BIT];
        default: ;
      endcase
    end

    // conversion sequence
    case (seq_r.state)
      ST_IDLE: ;
      ST_HELD: ;
      ST_SAMPLE:
      begin
        // first converter tick closes the sample, tries the top bit
        if (conv_tick)
        begin
          seq_nxt.trial = bit_weight(3'd7);
          seq_nxt.bit_idx = 3'd7;
          seq_nxt.state = ST_CONVERT;
        end
      end
      ST_CONVERT:
      begin
        if (conv_tick)
        begin
          // keep the trial bit only if the input is above it
          if (!comparator_above)
          begin
            seq_nxt.trial = seq_r.trial & ~bit_weight(seq_r.bit_idx);
          end
          if (seq_r.bit_idx == 3'd0)
          begin
            // final code lands in the result register
            seq_nxt.result = comparator_above ? seq_r.trial
                                              : (seq_r.trial & ~bit_weight(3'd0));
            // flag drops once the code is complete
            seq_nxt.pending = 1'b0;
            seq_nxt.state = ST_IDLE;
          end
          else
          begin
            seq_nxt.trial = (comparator_above ? seq_r.trial
                             : (seq_r.trial & ~bit_weight(seq_r.bit_idx)))
                            | bit_weight(seq_r.bit_idx - 3'd1);
            seq_nxt.bit_idx = seq_r.bit_idx - 3'd1;
          end
        end
      end
      default: seq_nxt.state = ST_IDLE;
    endcase

    // start edges override the sequence; a rise aborts a running one
    if (start_rise)
    begin
      // rising start holds converter, raises flag
      seq_nxt.pending = 1'b1;
      seq_nxt.trial = '0;
      seq_nxt.bit_idx = '0;
      seq_nxt.state = ST_HELD;
    end
    else if (start_fall && seq_r.state == ST_HELD && seq_r.ctl.port_analog_config != 3'b000)
    begin
      seq_nxt.state = ST_SAMPLE;
      seq_nxt.sample = 1'b1;
    end

    // completion event; set beats a same-cycle clear
    if (bus_req.wr && bus_req.addr == OFS_EVENT_STATUS && bus_req.wdata[EVT_DONE_BIT])
    begin
      seq_nxt.evt_status = 1'b0;
    end
    if (done)
    begin
      seq_nxt.evt_status = 1'b1;
    end
    seq_nxt.irq = seq_nxt.evt_status && seq_nxt.evt_mask;

    // read data, one cycle after the strobe and zero otherwise
    seq_nxt.rdata = '0;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        // result read never disturbs the held value
        OFS_CONVERSION_RESULT: seq_nxt.rdata = seq_r.result;
        OFS_CONVERTER_CONTROL:
        begin
          seq_nxt.rdata = {seq_r.ctl.start, seq_r.pending,
                           seq_r.ctl.port_analog_config, seq_r.ctl.channel_select};
        end
        OFS_CONVERTER_CLOCK_SELECT:
        begin
          seq_nxt.rdata = {seq_r.test_bit, 5'h00, seq_r.clock_divider_select};
        end
        OFS_EVENT_STATUS: seq_nxt.rdata = {7'h00, seq_r.evt_status};
        OFS_EVENT_MASK: seq_nxt.rdata = {7'h00, seq_r.evt_mask};
        default: seq_nxt.rdata = '0;
      endcase
    end

    // analog front end controls
    // only the low two bits reach the multiplexer
    seq_nxt.channel = seq_nxt.ctl.channel_select[1:0];
    seq_nxt.analog_lines = analog_map(seq_nxt.ctl.port_analog_config);
    // converter powered only while some line is analog
    seq_nxt.power = (seq_nxt.ctl.port_analog_config != 3'b000);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      seq_r <= '0;
      seq_r.state <= ST_IDLE;
      seq_r.ctl <= adcs_ctl_s'({RST_CONVERTER_CONTROL[CTL_START_BIT],
                                RST_CONVERTER_CONTROL[CTL_PCR_LSB +: 3],
                                RST_CONVERTER_CONTROL[CTL_ACS_LSB +: 3]});
      seq_r.pending <= RST_PENDING_FLAG;
      seq_r.clock_divider_select <= RST_CONVERTER_CLOCK_SELECT[1:0];
      seq_r.result <= RST_CONVERSION_RESULT;
      seq_r.evt_mask <= RST_EVENT_MASK[EVT_DONE_BIT];
    end
    else
    begin
      seq_r <= seq_nxt;
    end
  end

  // outputs straight from the state flops
  assign rdata = seq_r.rdata;
  assign trial_code = seq_r.trial;
  assign channel_select = seq_r.channel;
  assign port_b_lines_analog = seq_r.analog_lines;
  assign converter_power = seq_r.power;
  assign sample_hold = seq_r.sample;
  assign irq = seq_r.irq;

endmodule // adcs_sequencer

// File: bench/adcs_sequencer_props.sv
// checker for the converter sequencer ports
`timescale 1ns/1ps
module adcs_sequencer_props
  import adcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire adcs_bus_req_s bus_req,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic comparator_above,
  input wire logic [RESULT_W-1:0] trial_code,
  input wire logic [1:0] channel_select,
  input wire logic [CHANNELS-1:0] port_b_lines_analog,
  input wire logic converter_power,
  input wire logic sample_hold,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic start_r;
  logic pcr_r;
  logic [7:0] wd_r;
  logic ctl_wr;
  logic launch;
  // ------------------------------------------------
  // shadow of the stored start bit and power
  // ------------------------------------------------
  function automatic logic [3:0] lines_of(input logic [2:0] p);
    return p[2] ? 4'hf : (4'h1 << p[1:0]) - 4'h1;
  endfunction
  // launch only from a stored one with power already stored
  assign ctl_wr = bus_req.wr && bus_req.addr == OFS_CONVERTER_CONTROL;
  assign launch = ctl_wr && !bus_req.wdata[7] && start_r && pcr_r;
  // shadow registers follow every control write
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      start_r <= 1'b0;
      pcr_r <= 1'b0;
      wd_r <= 8'h00;
    end
    else
    begin
      wd_r <= bus_req.wdata;
      if (ctl_wr)
      begin
        start_r <= bus_req.wdata[7];
        pcr_r <= |bus_req.wdata[5:3];
      end
    end
  end
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  a_rdata_idle_zero: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_ctl_lines_map: assert property (ctl_wr |=> port_b_lines_analog == lines_of(wd_r[5:3]))
    else $error("analog line map wrong");
  a_ctl_power_on: assert property (ctl_wr |=> converter_power == |wd_r[5:3])
    else $error("converter power wrong");
  a_ctl_chan_pick: assert property (ctl_wr |=> channel_select == wd_r[1:0])
    else $error("channel select wrong");
  a_power_lines_agree: assert property (converter_power == |port_b_lines_analog)
    else $error("power and lines disagree");
  a_launch_gives_hold: assert property (launch |=> sample_hold)
    else $error("no sample pulse after launch");
  a_hold_has_cause: assert property (sample_hold |-> $past(launch))
    else $error("sample pulse without launch");
  a_hold_single_cycle: assert property (sample_hold |=> !sample_hold)
    else $error("sample pulse too long");
  a_first_trial_msb: assert property (sample_hold |-> ##[1:40] trial_code == 8'h80)
    else $error("first trial code missing");
  c_launch: cover property (sample_hold);
  c_irq: cover property ($rose(irq));
  c_result_read: cover property (bus_req.rd && bus_req.addr == OFS_CONVERSION_RESULT);
endmodule // adcs_sequencer_props

bind adcs_sequencer adcs_sequencer_props i_props (.core_clk(core_clk), .rst(rst),
  .bus_req(bus_req), .rdata(rdata), .comparator_above(comparator_above),
  .trial_code(trial_code), .channel_select(channel_select),
  .port_b_lines_analog(port_b_lines_analog), .converter_power(converter_power),
  .sample_hold(sample_hold), .irq(irq));

// File: bench/adcs_analog_model.sv
// comparator model standing for the four analog port lines
`timescale 1ns/1ps
module adcs_analog_model
  import adcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic [31:0] levels,
  input wire logic [1:0] channel_select,
  input wire logic [RESULT_W-1:0] trial_code,
  input wire logic converter_power,
  output logic comparator_above
);
  logic wobble_r = 1'b0;
  // unpowered front end gives no steady answer
  always_ff @(posedge core_clk)
  begin
    wobble_r <= !wobble_r;
  end
  always_comb
  begin
    if (converter_power)
      comparator_above = levels[{channel_select, 3'b000} +: 8] >= trial_code;
    else
      comparator_above = wobble_r;
  end
endmodule // adcs_analog_model

// File: bench/tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_top
  import adcs_pkg::*;
();
  typedef struct packed {logic [7:0] cfg; logic [3:0] lines; logic pwr; logic [1:0] chan;} adcs_row_s;
  logic core_clk, rst, comparator_above, converter_power, sample_hold, irq;
  adcs_bus_req_s bus_req;
  logic [7:0] rdata, trial_code, rd_v, last_res;
  logic [1:0] channel_select;
  logic [3:0] port_b_lines_analog;
  logic [31:0] levels = 32'hff01_5ac3;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  adcs_row_s rows [7] = '{'{8'h20, 4'hf, 1, 0}, '{8'h08, 4'h1, 1, 0}, '{8'h11, 4'h3, 1, 1},
    '{8'h1a, 4'h7, 1, 2}, '{8'h23, 4'hf, 1, 3}, '{8'h60, 4'hf, 1, 0}, '{8'h00, 4'h0, 0, 0}};
  adcs_sequencer i_adcs_sequencer (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .comparator_above(comparator_above), .trial_code(trial_code),
    .channel_select(channel_select), .port_b_lines_analog(port_b_lines_analog),
    .converter_power(converter_power), .sample_hold(sample_hold), .irq(irq));
  adcs_analog_model i_adcs_analog_model (.core_clk(core_clk), .levels(levels),
    .channel_select(channel_select), .trial_code(trial_code),
    .converter_power(converter_power), .comparator_above(comparator_above));
  // ------------------------------------------------
  // clock, timeout and shared tasks
  // ------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = !core_clk;
  end
  // hang guard, far above the longest run
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one idle cycle after each access keeps strobes single
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
    // data launched at the strobe edge still stands here
    rd_v = rdata;
  endtask
  // full conversion: rise, fall, poll, read, clear
  task automatic conv(input logic [1:0] ch, input logic [1:0] div, input logic msk);
    logic [7:0] cfg;
    int n;
    int per;
    cfg = {6'b001000, ch};
    n = 0;
    per = (div == DIV_SEL_2) ? 2 : (div == DIV_SEL_8) ? 8 : 32;
    wr(OFS_CONVERTER_CLOCK_SELECT, {6'h00, div});
    wr(OFS_EVENT_MASK, {7'h00, msk});
    wr(OFS_CONVERTER_CONTROL, 8'h80 | cfg);
    rd(OFS_CONVERTER_CONTROL);
    check("ctl_after_rise", rd_v, 8'hc0 | cfg);
    rd(OFS_CONVERSION_RESULT);
    check("held_result", rd_v, last_res);
    wr(OFS_CONVERTER_CONTROL, cfg);
    do
    begin
      rd(OFS_CONVERTER_CONTROL);
      n += 2;
    end
    while (rd_v[6] && n < 400);
    check("ctl_done", rd_v, cfg);
    check("conv_cycles", n >= 9 * per - 2 && n <= 9 * per + 6, 1);
    rd(OFS_CONVERSION_RESULT);
    last_res = levels[{ch, 3'b000} +: 8];
    check("result", rd_v, last_res);
    check("irq_level", irq, msk);
    rd(OFS_EVENT_STATUS);
    check("status_set", rd_v, 8'h01);
    wr(OFS_EVENT_STATUS, 8'h01);
    check("irq_cleared", irq, 0);
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    rst = 1'b1;
    bus_req = '0;
    last_res = 8'h00;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check("reset_outs", {trial_code, port_b_lines_analog, channel_select, converter_power,
      sample_hold, irq}, 0);
    for (int a = 8'h21; a <= 8'h25; a++)
    begin
      rd(a[7:0]);
      check("reset_reg", rd_v, 8'h00);
    end
    foreach (rows[i])
    begin
      wr(OFS_CONVERTER_CONTROL, rows[i].cfg);
      check("ctl_outs", {port_b_lines_analog, converter_power, channel_select},
        {rows[i].lines, rows[i].pwr, rows[i].chan});
      rd(OFS_CONVERTER_CONTROL);
      check("ctl_read", rd_v, {2'b00, rows[i].cfg[5:0]});
    end
    wr(OFS_CONVERTER_CLOCK_SELECT, 8'h01);
    rd(OFS_CONVERTER_CLOCK_SELECT);
    check("clk_sel", rd_v, 8'h01);
    conv(2'd1, DIV_SEL_2, 1'b0);
    conv(2'd2, DIV_SEL_8, 1'b1);
    conv(2'd3, DIV_SEL_32, 1'b0);
    // fourth conversion, on channel 0, right after the status clear
    conv(2'd0, DIV_SEL_8, 1'b1);
    // fall without power must not launch
    wr(OFS_CONVERTER_CONTROL, 8'h80);
    wr(OFS_CONVERTER_CONTROL, 8'h00);
    rd(OFS_CONVERTER_CONTROL);
    check("no_launch", rd_v, 8'h40);
    wr(8'h30, 8'hff);
    rd(8'h30);
    check("unmapped", rd_v, 8'h00);
    // reset in mid conversion
    wr(OFS_CONVERTER_CONTROL, 8'ha1);
    wr(OFS_CONVERTER_CONTROL, 8'h21);
    rst <= 1'b1;
    @(posedge core_clk);
    check("mid_reset", {trial_code, port_b_lines_analog, sample_hold, irq}, 0);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(OFS_CONVERTER_CONTROL);
    check("ctl_after_reset", rd_v, 8'h00);
    complete_run();
  end
endmodule // tb_top
